//--- src/rwi_pkg.sv
// package: offsets, reset values and encodings for the reset/wake-up state block
// ==========================================================================
package rwi_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_EN = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
    localparam logic [7:0] OFF_PC = 8'h10;
    localparam logic [7:0] OFF_STACK_TOP = 8'h14;
    localparam logic [7:0] OFF_STK_PTR = 8'h18;
    localparam logic [7:0] OFF_FLAGS = 8'h1c;
    localparam logic [7:0] OFF_PORT_A_DIR = 8'h20;
    localparam logic [7:0] OFF_PORT_A_LAT = 8'h24;
    localparam logic [7:0] OFF_PORT_A_PIN = 8'h28;
    localparam logic [7:0] OFF_PORT_E_LAT = 8'h2c;
    localparam logic [7:0] OFF_PORT_E_PIN = 8'h30;
    localparam logic [7:0] OFF_EVENT = 8'h34;
    // event register bits (write 1 to request)
    localparam int EV_WAKE_WDT = 0;
    localparam int EV_WAKE_IRQ_HI = 1;
    localparam int EV_WAKE_IRQ_LO = 2;
    localparam int EV_RESET_FULL = 3;
    localparam int EV_RESET_WARM = 4;
    // ctrl register bits
    localparam int CTRL_HI_EN = 0;
    localparam int CTRL_LO_EN = 1;
    localparam int CTRL_OSC_FREE = 2;
    localparam int CTRL_CLR_PIN_OFF = 3;
    // interrupt flag bits
    localparam int FLAG_WDT = 0;
    localparam int FLAG_HI = 1;
    localparam int FLAG_LO = 2;
    // vectors and reset values
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] PORT_A_PIN_MASK = 8'h3f;
    localparam logic [7:0] PORT_A_WARM_MASK = 8'hd0; // pin bits 5,3..0 read 0 after reset
    localparam logic [3:0] PORT_E_BIT3_MASK = 4'h7;
    localparam logic [4:0] STK_DEPTH_MAX = 5'h1f;
    localparam logic [2:0] STATUS_W = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- src/rwi_stack_slot.sv
// one hardware stack slot: loads a return address on push
`timescale 1ns/100ps
`default_nettype none
module rwi_stack_slot
    import rwi_pkg::*;
#(
    parameter int AW = 21
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic load,
    input wire logic [AW-1:0] din,
    output logic [AW-1:0] dout
);
    typedef struct packed {
        logic [AW-1:0] val;
    } slot_st_t;
    slot_st_t st_r;
    slot_st_t st_nxt;

    // load on push only
    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.val = din;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.val;
endmodule
`default_nettype wire

//--- src/reset_wakeup_state_init.sv
// reset and wake-up state initialisation bank with axi4-lite register access
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module reset_wakeup_state_init
    import rwi_pkg::*;
#(
    parameter int DEPTH = 31
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] port_a_pins,
    input wire logic [3:0] port_e_pins,
    output logic irq
);
    // ==================================================================
    // state
    typedef struct packed {
        // write channel
        logic aw_got;
        logic w_got;
        logic awready;
        logic wready;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        // read channel
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // control, status and interrupt
        logic [3:0] ctrl;
        logic [2:0] status;
        logic [2:0] irq_en;
        logic irq;
        // core state saved on wake-up
        logic [20:0] pc;
        logic [4:0] stk_ptr;
        logic [2:0] flags;
        // port registers
        logic [7:0] port_a_direction;
        logic [7:0] port_a_output_latch;
        logic [7:0] port_a_pin_reg;
        logic [3:0] port_e_output_latch;
        logic [3:0] port_e_pin_reg;
    } st_t;
    st_t st_r;
    st_t st_nxt;
    logic push;
    logic [20:0] slot_q [DEPTH];
    logic [20:0] stack_top;

    // ==================================================================
    // hardware stack slots
    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
        rwi_stack_slot #(.AW(21)) u_slot (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .load(push && (st_r.stk_ptr == 5'(i))),
            .din(st_r.pc),
            .dout(slot_q[i])
        );
    end
    // top of stack is the slot below the pointer
    assign stack_top = (st_r.stk_ptr == 5'h00) ? 21'h000000 :
        slot_q[st_r.stk_ptr - 5'h01];

    // ==================================================================
    // next-state logic
    always_comb begin
        logic wr_go;
        logic [2:0] ev;
        logic [2:0] set_bits;
        logic [7:0] a_en;
        logic [3:0] e_en;
        wr_go = 1'b0;
        ev = 3'h0;
        set_bits = 3'h0;
        a_en = st_r.ctrl[CTRL_OSC_FREE] ? 8'hff : PORT_A_PIN_MASK;
        e_en = st_r.ctrl[CTRL_CLR_PIN_OFF] ? 4'hf : PORT_E_BIT3_MASK;
        push = 1'b0;
        st_nxt = st_r;
        // pins sampled each cycle, masked bits read zero
        st_nxt.port_a_pin_reg = port_a_pins & a_en;
        st_nxt.port_e_pin_reg = port_e_pins & e_en;
        // write channel capture
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // perform the write once both halves are in and no response pending
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            wr_go = 1'b1;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            unique case (st_r.awaddr)
                OFF_CTRL: st_nxt.ctrl = st_r.wdata[3:0];
                OFF_IRQ_EN: st_nxt.irq_en = st_r.wdata[2:0];
                OFF_IRQ_CLR: ;
                OFF_PORT_A_DIR: st_nxt.port_a_direction = st_r.wdata[7:0] & a_en;
                OFF_PORT_A_LAT: st_nxt.port_a_output_latch = st_r.wdata[7:0] & a_en;
                OFF_PORT_E_LAT: st_nxt.port_e_output_latch = st_r.wdata[3:0] & e_en;
                OFF_EVENT: ev = st_r.wdata[2:0];
                default: st_nxt.bresp = RESP_SLVERR;
            endcase
        end
        // readies are registered: a channel is offered again once its slot has emptied
        st_nxt.awready = !st_nxt.aw_got;
        st_nxt.wready = !st_nxt.w_got;
        // wake-up: record the cause in the flags
        set_bits[FLAG_WDT] = ev[EV_WAKE_WDT];
        set_bits[FLAG_HI] = ev[EV_WAKE_IRQ_HI];
        set_bits[FLAG_LO] = ev[EV_WAKE_IRQ_LO];
        st_nxt.flags = st_r.flags | set_bits;
        // interrupt wake-up with enable: push pc unless the stack is full, load the vector, high wins
        if (ev[EV_WAKE_IRQ_HI] && st_r.ctrl[CTRL_HI_EN]) begin
            push = (st_r.stk_ptr != STK_DEPTH_MAX);
            st_nxt.stk_ptr = push ? st_r.stk_ptr + 5'h01 : st_r.stk_ptr;
            st_nxt.pc = VEC_HIGH;
        end else if (ev[EV_WAKE_IRQ_LO] && st_r.ctrl[CTRL_LO_EN]) begin
            push = (st_r.stk_ptr != STK_DEPTH_MAX);
            st_nxt.stk_ptr = push ? st_r.stk_ptr + 5'h01 : st_r.stk_ptr;
            st_nxt.pc = VEC_LOW;
        end
        // software resets; direction registers untouched by wake-up
        if (wr_go && st_r.awaddr == OFF_EVENT &&
                (st_r.wdata[EV_RESET_FULL] || st_r.wdata[EV_RESET_WARM])) begin
            st_nxt.pc = PC_RESET;
            st_nxt.stk_ptr = 5'h00;
            st_nxt.flags = 3'h0;
            st_nxt.port_a_direction = DIR_RESET & a_en;
            st_nxt.port_a_pin_reg = port_a_pins & a_en & PORT_A_WARM_MASK;
            push = 1'b0;
        end
        // sticky status: set wins over clear
        st_nxt.status = st_r.status;
        if (wr_go && st_r.awaddr == OFF_IRQ_CLR) begin
            st_nxt.status = st_r.status & ~st_r.wdata[2:0];
        end
        st_nxt.status = st_nxt.status | set_bits;
        st_nxt.irq = |(st_nxt.status & st_nxt.irq_en);
        // read channel
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                OFF_CTRL: st_nxt.rdata = {28'h0, st_r.ctrl};
                OFF_STATUS: st_nxt.rdata = {29'h0, st_r.status};
                OFF_IRQ_EN: st_nxt.rdata = {29'h0, st_r.irq_en};
                OFF_IRQ_CLR: st_nxt.rdata = 32'h0;
                OFF_PC: st_nxt.rdata = {11'h0, st_r.pc};
                OFF_STACK_TOP: st_nxt.rdata = {11'h0, stack_top};
                OFF_STK_PTR: st_nxt.rdata = {27'h0, st_r.stk_ptr};
                OFF_FLAGS: st_nxt.rdata = {29'h0, st_r.flags};
                OFF_PORT_A_DIR: st_nxt.rdata = {24'h0, st_r.port_a_direction & a_en};
                OFF_PORT_A_LAT: st_nxt.rdata = {24'h0, st_r.port_a_output_latch & a_en};
                OFF_PORT_A_PIN: st_nxt.rdata = {24'h0, st_r.port_a_pin_reg};
                OFF_PORT_E_LAT: st_nxt.rdata = {28'h0, st_r.port_e_output_latch & e_en};
                OFF_PORT_E_PIN: st_nxt.rdata = {28'h0, st_r.port_e_pin_reg};
                OFF_EVENT: st_nxt.rdata = 32'h0;
                default: begin
                    st_nxt.rdata = 32'h0;
                    st_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        // read address is offered again once the read data has been taken
        st_nxt.arready = !st_nxt.rvalid;
    end

    // ==================================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // everything clears, readies included; port a pins 5..0 come up as inputs
            st_r <= '0;
            st_r.port_a_direction <= DIR_RESET & PORT_A_PIN_MASK;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ==================================================================
    // outputs, each straight from a flip-flop; readies lag ce by a cycle, so a
    // master must not offer a request while ce is low or the request is lost
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign irq = st_r.irq;

    // ==================================================================
    // checks
    // event-register write about to take effect, and its reset-bit subset
    logic ev_go;
    logic soft_rst_go;
    assign ev_go = ce && st_r.aw_got && st_r.w_got && !st_r.bvalid
        && st_r.awaddr == OFF_EVENT;
    assign soft_rst_go = ev_go && (st_r.wdata[EV_RESET_FULL] || st_r.wdata[EV_RESET_WARM]);

    // high-priority wake with its enable loads the high vector
    vector_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.awaddr == OFF_EVENT
        && st_r.wdata[EV_WAKE_IRQ_HI] && !st_r.wdata[EV_RESET_FULL]
        && !st_r.wdata[EV_RESET_WARM] && st_r.ctrl[CTRL_HI_EN]
        |=> st_r.pc == VEC_HIGH) else $error("high vector not loaded");
    // low-priority wake loads the low vector unless the high one wins
    vector_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_go && !soft_rst_go && st_r.wdata[EV_WAKE_IRQ_LO] && st_r.ctrl[CTRL_LO_EN]
        && !(st_r.wdata[EV_WAKE_IRQ_HI] && st_r.ctrl[CTRL_HI_EN])
        |=> st_r.pc == VEC_LOW) else $error("low vector not loaded");

    // a push advances the pointer by one
    stack_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && push |=> st_r.stk_ptr == $past(st_r.stk_ptr) + 5'h01)
        else $error("stack pointer did not advance");
    // the pushed return address shows as stack top
    stack_save_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && push |=> stack_top == $past(st_r.pc))
        else $error("return address not saved");
    // without a push or a software reset the pointer stays put
    stack_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !push && !soft_rst_go |=> st_r.stk_ptr == $past(st_r.stk_ptr))
        else $error("stack pointer moved");

    // watchdog wake is flagged in flags and status
    wake_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.awaddr == OFF_EVENT
        && st_r.wdata[EV_WAKE_WDT] && !st_r.wdata[EV_RESET_FULL]
        && !st_r.wdata[EV_RESET_WARM] |=> st_r.flags[FLAG_WDT] && st_r.status[FLAG_WDT])
        else $error("wake cause not flagged");
    // every wake cause written without a software reset leaves its flag set
    wake_any_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_go && !soft_rst_go && st_r.wdata[2:0] != 3'h0
        |=> (st_r.flags & $past(st_r.wdata[2:0])) == $past(st_r.wdata[2:0]))
        else $error("wake cause lost");

    // port a high bits read zero while the oscillator holds them
    osc_pins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_r.ctrl[CTRL_OSC_FREE] |-> st_r.port_a_pin_reg[7:6] == 2'b00 ||
        $past(st_r.ctrl[CTRL_OSC_FREE])) else $error("port a high bits live");
    // port e bit 3 reads zero while the clear pin is active
    clear_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_r.ctrl[CTRL_CLR_PIN_OFF] && !$past(st_r.ctrl[CTRL_CLR_PIN_OFF])
        |-> !st_r.port_e_pin_reg[3]) else $error("port e bit 3 live");
    // direction changes only through a register write
    dir_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !(st_r.aw_got && st_r.w_got && !st_r.bvalid)
        |=> st_r.port_a_direction == $past(st_r.port_a_direction))
        else $error("direction changed without write");
    // a software reset turns every enabled direction bit to input
    dir_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        soft_rst_go |=> st_r.port_a_direction
        == (DIR_RESET & (st_r.ctrl[CTRL_OSC_FREE] ? 8'hff : PORT_A_PIN_MASK)))
        else $error("direction not reset");

    // interrupt line follows the enabled status bits
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == |(st_r.status & st_r.irq_en)) else $error("irq mismatch");
    // write response stands until taken
    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");

    // main scenarios
    wake_hi_c: cover property (@(posedge aclk) st_r.pc == VEC_HIGH);
    wake_lo_c: cover property (@(posedge aclk) st_r.pc == VEC_LOW);
    irq_c: cover property (@(posedge aclk) irq);
    push_c: cover property (@(posedge aclk) ce && push);
    soft_rst_c: cover property (@(posedge aclk) soft_rst_go);
endmodule
`default_nettype wire

//--- test/reset_wakeup_state_init_tb_top.sv
// self-checking testbench for the reset and wake-up state bank
`timescale 1ns/100ps
`default_nettype none
module reset_wakeup_state_init_tb_top;
    import rwi_pkg::*;
    logic aclk, aresetn, ce;
    logic [7:0] awaddr, araddr, pa;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] pe;
    logic [1:0] bresp, rresp, rsp;
    logic irq;
    int fail_count, n_tests, cyc;

    // =====================================================
    // clock, timeout and design
    initial begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end
    // a hang counts as a mismatch
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    reset_wakeup_state_init dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_pins(pa),
        .port_e_pins(pe), .irq(irq));

    // =====================================================
    // bus tasks and comparison
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // write: address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ad = 1;
                awvalid <= 0;
            end
            if (wvalid && wready) begin
                wd = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        rsp = bresp;
        bready <= 0;
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        rsp = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        rdr(a);
        chk(nm, rd, exp);
    endtask

    // =====================================================
    // scenarios
    task automatic t_reset;
        rchk("dir_reset", OFF_PORT_A_DIR, 32'h0000003f);
        rchk("pc_reset", OFF_PC, 32'h0);
        rchk("sp_reset", OFF_STK_PTR, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_irq_wake;
        wr(OFF_PORT_A_DIR, 32'h15);
        wr(OFF_CTRL, 32'h1); // high enable only
        wr(OFF_EVENT, 32'h2);
        rchk("pc_high", OFF_PC, {11'h0, VEC_HIGH});
        rchk("sp_one", OFF_STK_PTR, 32'h1);
        rchk("tos_one", OFF_STACK_TOP, {11'h0, PC_RESET});
        rchk("flag_high", OFF_FLAGS, 32'h2);
        wr(OFF_CTRL, 32'h2); // low enable only
        wr(OFF_EVENT, 32'h4);
        rchk("pc_low", OFF_PC, {11'h0, VEC_LOW});
        rchk("sp_two", OFF_STK_PTR, 32'h2);
        rchk("tos_two", OFF_STACK_TOP, {11'h0, VEC_HIGH});
        wr(OFF_CTRL, 32'h0); // no interrupt enable; a watchdog wake loads no vector
        wr(OFF_EVENT, 32'h1);
        rchk("pc_wdt", OFF_PC, {11'h0, VEC_LOW});
        rchk("sp_wdt", OFF_STK_PTR, 32'h2);
        rchk("flag_all", OFF_FLAGS, 32'h7);
        rchk("dir_kept", OFF_PORT_A_DIR, 32'h15);
        $display("test wake done");
    endtask
    task automatic t_intr;
        wr(OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq_masked", irq, 1'b0);
        wr(OFF_IRQ_EN, 32'h2);
        repeat (2) @(posedge aclk);
        chk("irq_on", irq, 1'b1);
        wr(OFF_IRQ_CLR, 32'h2);
        repeat (2) @(posedge aclk);
        chk("irq_off", irq, 1'b0);
        rchk("status_clr", OFF_STATUS, 32'h5);
        $display("test interrupt done");
    endtask
    task automatic t_ports;
        pa <= 8'hff;
        pe <= 4'hf;
        wr(OFF_PORT_A_LAT, 32'hff);
        wr(OFF_PORT_E_LAT, 32'hf);
        rchk("port_a_output_latch_hid", OFF_PORT_A_LAT, 32'h3f);
        rchk("pina_hid", OFF_PORT_A_PIN, 32'h3f);
        rchk("late_hid", OFF_PORT_E_LAT, 32'h7);
        rchk("pine_hid", OFF_PORT_E_PIN, 32'h7);
        wr(OFF_CTRL, 32'hc); // oscillator frees pins, master clear off
        wr(OFF_PORT_A_LAT, 32'hff);
        wr(OFF_PORT_E_LAT, 32'hf);
        wr(OFF_PORT_A_DIR, 32'hc0);
        rchk("port_a_output_latch_on", OFF_PORT_A_LAT, 32'hff);
        rchk("pina_on", OFF_PORT_A_PIN, 32'hff);
        rchk("dira_on", OFF_PORT_A_DIR, 32'hc0);
        rchk("late_on", OFF_PORT_E_LAT, 32'hf);
        rchk("pine_on", OFF_PORT_E_PIN, 32'hf);
        $display("test ports done");
    endtask
    task automatic t_errors;
        rdr(8'hfc);
        chk("unmapped", {rsp, rd[29:0]}, {RESP_SLVERR, 30'h0});
        wr(OFF_PC, 32'h55);
        chk("ro_write", rsp, RESP_SLVERR);
        $display("test errors done");
    endtask
    task automatic t_soft_rst;
        wr(OFF_CTRL, 32'h5); // high enable, oscillator frees pins
        chk("wr_okay", rsp, RESP_OKAY);
        wr(OFF_EVENT, 32'h12); // warm reset beats a high wake in one write
        rchk("pc_soft", OFF_PC, {11'h0, PC_RESET});
        rchk("sp_soft", OFF_STK_PTR, 32'h0);
        rchk("flag_soft", OFF_FLAGS, 32'h0);
        rchk("dir_soft", OFF_PORT_A_DIR, {24'h0, DIR_RESET});
        wr(OFF_CTRL, 32'h0); // oscillator takes pins back, clear pin active
        rchk("port_a_output_latch_hide", OFF_PORT_A_LAT, 32'h3f);
        rchk("pine_hide", OFF_PORT_E_PIN, 32'h7);
        wr(OFF_PORT_A_DIR, 32'h0);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rchk("dir_hard", OFF_PORT_A_DIR, {24'h0, DIR_RESET & PORT_A_PIN_MASK});
        $display("test soft reset done");
    endtask

    // =====================================================
    // closing report
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        aresetn = 0;
        ce = 1;
        awaddr = 0;
        araddr = 0;
        wdata = 0;
        awvalid = 0;
        wvalid = 0;
        bready = 0;
        arvalid = 0;
        rready = 0;
        pa = 0;
        pe = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_irq_wake();
        t_intr();
        t_ports();
        t_soft_rst();
        t_errors();
        results();
    end
endmodule
`default_nettype wire
